// file: hdl/brte_device.sv
// device end: tap controller, test-control register, boundary chain and run-test engine
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01 - eight control bits mask signature inputs
// R02 - top mask bit is pin eight, driving side
// R03 - unmasked inputs compress, masked inputs ignored
// R04 - sample mode captures inputs every rising edge
// R05 - toggle mode inverts outputs, driven on falling
// R06 - pattern mode steps sixteen-bit feedback register
// R07 - host seeds chain first; zero seed stalls
// R08 - signature mode folds inputs into sixteen bits
// R09 - signature-only mode holds output shadows
// R10 - combined mode: eight-bit signature plus pattern
// R11 - combined mode: signature plus eight-bit counter
// R12 - opposite outputs count carries, sixteen total
// R13 - all on test clock, inputs sampled rising
// R14 - tdo and outputs change on falling edge
// R15 - host changes tms on falling edges
// R16 - serial data only in shift states
// R17 - tms low leaves reset toward idle
// R18 - low three control bits select operation
// R19 - runs only with run-test in idle
// R20 - exactly one direction, else behave as bypass
// R21 - maximal-length feedback polynomials chosen
module brte_device
  import brte_pkg::*;
(
  brte_link_if.dev link,
  input wire logic [7:0] a_side_pins_in,
  input wire logic [7:0] b_side_pins_in,
  input wire logic a_to_b_output_enable,
  input wire logic b_to_a_output_enable_n,
  output logic [7:0] a_side_pins_out,
  output logic [7:0] b_side_pins_out,
  output logic [7:0] a_side_core,
  output logic [7:0] b_side_core
);
  brte_tap_t state, next_state;
  logic [7:0] ir_shift, next_ir_shift;
  logic [7:0] instr, next_instr;
  logic bypass_bit, next_bypass_bit;
  logic [10:0] ctrl_shift, next_ctrl_shift;
  logic [10:0] ctrl, next_ctrl;
  logic [31:0] chain, next_chain;
  logic [7:0] a_meta, a_sync, b_meta, b_sync;
  logic [1:0] oe_meta, oe_sync;
  logic [7:0] next_a_out, next_b_out, next_a_core, next_b_core;
  logic next_tdo, next_tdo_oe;
  logic tdo_r, tdo_oe_r;
  logic dir_ab, dir_ba, dir_ok, run_ok;
  logic [2:0] op;
  logic [7:0] sel_in, sel_out, opp_out, sel_pins, psa_in;
  logic [7:0] new_in, new_out, new_opp;
  logic [15:0] lfsr16, w16;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; pins are asynchronous to the test clock
  always_ff @(posedge link.tck) begin
    a_meta <= a_side_pins_in; // R13
    a_sync <= a_meta;
    b_meta <= b_side_pins_in; // R13
    b_sync <= b_meta;
    oe_meta <= {a_to_b_output_enable, b_to_a_output_enable_n};
    oe_sync <= oe_meta;
  end

  assign dir_ab = oe_sync[1] & oe_sync[0];
  assign dir_ba = ~oe_sync[1] & ~oe_sync[0];
  assign dir_ok = dir_ab | dir_ba; // R20
  assign run_ok = (instr == IR_RUN_TEST) && dir_ok && (state == TAP_RTI); // R19
  assign op = ctrl[OP_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // tap controller; an unknown state falls to reset so tms high recovers it
  always_comb begin
    case (state)
      TAP_TLR: next_state = link.tms ? TAP_TLR : TAP_RTI; // R17
      TAP_RTI: next_state = link.tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: next_state = link.tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_state = link.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: next_state = link.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: next_state = link.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_state = link.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: next_state = link.tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: next_state = link.tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: next_state = link.tms ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: next_state = link.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: next_state = link.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: next_state = link.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_state = link.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: next_state = link.tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: next_state = link.tms ? TAP_SEL_DR : TAP_RTI;
      default: next_state = TAP_TLR;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // run-test engine: selected cells depend on the flow direction
  always_comb begin
    sel_in = dir_ab ? chain[A_IN_LSB +: 8] : chain[B_IN_LSB +: 8];
    sel_out = dir_ab ? chain[B_OUT_LSB +: 8] : chain[A_OUT_LSB +: 8];
    opp_out = dir_ab ? chain[A_OUT_LSB +: 8] : chain[B_OUT_LSB +: 8];
    sel_pins = dir_ab ? a_sync : b_sync;
    // bit 10 masks pin eight, bit 3 pin one
    psa_in = sel_pins & ~ctrl[MASK_LSB +: 8]; // R01 R02 R03
    lfsr16 = {sel_out, sel_in};
    w16 = {lfsr16[14:0], ^(lfsr16 & TAPS16)}; // R21
    new_in = sel_in;
    new_out = sel_out;
    new_opp = opp_out;
    if (op[1:0] == 2'h0) begin
      new_in = sel_pins; // R04
      new_out = ~sel_out; // R05
    end else if (op[1:0] == 2'h1) begin
      // an all-zero seed stays zero; seeding is the host's job
      {new_out, new_in} = w16; // R06 R07
    end else if (op[1:0] == 2'h2) begin
      {new_out, new_in} = w16 ^ {8'h00, psa_in}; // R08
    end else begin
      new_in = {sel_in[6:0], ^(sel_in & TAPS8)} ^ psa_in; // R10 R11 R21
      if (op[2]) begin
        new_out = sel_out + 8'h01; // R11
        new_opp = opp_out + {7'h00, &sel_out}; // R12
      end else begin
        new_out = {sel_out[6:0], ^(sel_out & TAPS8)}; // R10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rising-edge state: shifts, captures and engine steps
  always_comb begin
    next_ir_shift = ir_shift;
    next_bypass_bit = bypass_bit;
    next_ctrl_shift = ctrl_shift;
    next_chain = chain;
    case (state)
      TAP_TLR: begin
        next_ctrl_shift = CTRL_RESET;
        next_chain = '0;
      end
      TAP_CAP_IR: next_ir_shift = IR_CAPTURE;
      TAP_SHIFT_IR: next_ir_shift = {link.tdi, ir_shift[7:1]}; // R16
      TAP_CAP_DR: next_bypass_bit = 1'b0;
      TAP_SHIFT_DR: begin
        // R16
        if (instr == IR_CHAIN_READ) begin
          next_chain = {link.tdi, chain[CHAIN_LEN-1:1]};
        end else if (instr == IR_CTRL_SCAN) begin
          next_ctrl_shift = {link.tdi, ctrl_shift[CTRL_LEN-1:1]};
        end else begin
          next_bypass_bit = link.tdi;
        end
      end
      TAP_RTI: begin
        if (run_ok) begin // R19 R20
          if (dir_ab) begin
            next_chain[A_IN_LSB +: 8] = new_in;
            next_chain[B_OUT_LSB +: 8] = new_out;
            next_chain[A_OUT_LSB +: 8] = new_opp;
          end else begin
            next_chain[B_IN_LSB +: 8] = new_in;
            next_chain[A_OUT_LSB +: 8] = new_out;
            next_chain[B_OUT_LSB +: 8] = new_opp;
          end
        end
      end
      default: next_chain = chain;
    endcase
  end

  always_ff @(posedge link.tck) begin
    state <= next_state; // R13 R15
    ir_shift <= next_ir_shift;
    bypass_bit <= next_bypass_bit;
    ctrl_shift <= next_ctrl_shift;
    chain <= next_chain;
  end

  ////////////////////////////////////////////////////////////////////////////
  // falling-edge state: updates, shadow latches and tdo
  always_comb begin
    next_instr = instr;
    next_ctrl = ctrl;
    next_a_out = a_side_pins_out;
    next_b_out = b_side_pins_out;
    next_a_core = a_side_core;
    next_b_core = b_side_core;
    next_tdo = tdo_r;
    next_tdo_oe = 1'b0;
    if (state == TAP_TLR) begin
      next_instr = IR_BYPASS;
      next_ctrl = CTRL_RESET;
      next_a_out = 8'h00;
      next_b_out = 8'h00;
      next_a_core = 8'h00;
      next_b_core = 8'h00;
    end
    if (state == TAP_UPD_IR) begin
      next_instr = ir_shift;
    end
    if (state == TAP_UPD_DR && instr == IR_CTRL_SCAN) begin
      next_ctrl = ctrl_shift; // R18
    end
    if (state == TAP_SHIFT_IR) begin
      next_tdo = ir_shift[0]; // R14 R16
      next_tdo_oe = 1'b1;
    end else if (state == TAP_SHIFT_DR) begin
      next_tdo_oe = 1'b1; // R16
      if (instr == IR_CHAIN_READ) begin
        next_tdo = chain[0];
      end else if (instr == IR_CTRL_SCAN) begin
        next_tdo = ctrl_shift[0];
      end else begin
        next_tdo = bypass_bit;
      end
    end
    if (run_ok) begin
      if (dir_ab) begin
        next_a_core = chain[A_IN_LSB +: 8]; // R04 R06 R08
      end else begin
        next_b_core = chain[B_IN_LSB +: 8]; // R04 R06 R08
      end
      // signature-only leaves the output shadows untouched
      if (op[1:0] != 2'h2) begin // R09
        if (dir_ab || op == 3'h7) begin
          next_b_out = chain[B_OUT_LSB +: 8]; // R05 R06 R10 R11 R12
        end
        if (dir_ba || op == 3'h7) begin
          next_a_out = chain[A_OUT_LSB +: 8]; // R05 R06 R10 R11 R12
        end
      end
    end
  end

  always_ff @(negedge link.tck) begin
    instr <= next_instr;
    ctrl <= next_ctrl;
    a_side_pins_out <= next_a_out; // R14
    b_side_pins_out <= next_b_out; // R14
    a_side_core <= next_a_core;
    b_side_core <= next_b_core;
    tdo_r <= next_tdo; // R14
    tdo_oe_r <= next_tdo_oe;
  end

  assign link.tdo = tdo_r;
  assign link.tdo_oe = tdo_oe_r;
endmodule
`default_nettype wire

// file: hdl/brte_pkg.sv
// constants and types shared by both ends of the boundary run-test link
package brte_pkg;
  // tap controller states
  typedef enum logic [3:0] {
    TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SHIFT_DR = 4'h4, TAP_EXIT1_DR = 4'h5, TAP_PAUSE_DR = 4'h6, TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SHIFT_IR = 4'hB,
    TAP_EXIT1_IR = 4'hC, TAP_PAUSE_IR = 4'hD, TAP_EXIT2_IR = 4'hE, TAP_UPD_IR = 4'hF
  } brte_tap_t;
  // host command kinds
  typedef enum logic [1:0] {
    CMD_RESET = 2'h0, CMD_IR = 2'h1, CMD_DR = 2'h2, CMD_IDLE = 2'h3
  } brte_cmd_t;
  // instruction register
  localparam logic [7:0] IR_CAPTURE = 8'h81;
  localparam logic [7:0] IR_BYPASS = 8'hFF;
  localparam logic [7:0] IR_CHAIN_READ = 8'h8B;
  localparam logic [7:0] IR_CTRL_SCAN = 8'h8E;
  localparam logic [7:0] IR_RUN_TEST = 8'h09;
  // test-control register layout
  localparam int CTRL_LEN = 11;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam int OP_LSB = 0;
  localparam int MASK_LSB = 3;
  // boundary chain layout: groups of eight shift stages, tdo end at bit 0
  localparam int CHAIN_LEN = 32;
  localparam int A_IN_LSB = 0;
  localparam int B_IN_LSB = 8;
  localparam int A_OUT_LSB = 16;
  localparam int B_OUT_LSB = 24;
  // feedback taps: x^16+x^14+x^13+x^11+1 and x^8+x^6+x^5+x^4+1
  localparam logic [15:0] TAPS16 = 16'hB400;
  localparam logic [7:0] TAPS8 = 8'hB8;
  // host link timing
  localparam int REF_PERIOD_NS = 40;
  localparam int TCK_HALF_NS = 80;
  localparam int TCK_HALF_CYC = (TCK_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int TCK_PERIOD_CYC = 2 * TCK_HALF_CYC;
endpackage

// file: hdl/brte_link_if.sv
// test access port wires between the controlling host and the device
`timescale 1ns/1ps
`default_nettype none
interface brte_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  modport host (output tck, output tms, output tdi, input tdo, input tdo_oe);
  modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
endinterface
`default_nettype wire

// file: hdl/brte_host.sv
// host end: drives the test access port from command requests on ref_clk
`timescale 1ns/1ps
`default_nettype none
module brte_host
  import brte_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  brte_link_if.host link,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [5:0] cmd_len,
  input wire logic [31:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_data
);
  logic busy, next_busy;
  logic [2:0] cnt, next_cnt;
  logic [6:0] step, next_step;
  logic [1:0] kind, next_kind;
  logic [5:0] len, next_len;
  logic [31:0] data, next_data;
  logic [31:0] acc, next_acc;
  logic tck_r, next_tck, tms_r, next_tms, tdi_r, next_tdi;
  logic next_ready, next_rsp_valid;
  logic [31:0] next_rsp_data;
  logic tdo_meta, tdo_sync, oe_meta, oe_sync;
  logic scan, samp_bit, in_shift;
  logic [6:0] hdr, shn, tail, total;

  // tdo comes from the tck domain; two flops before use
  always_ff @(posedge ref_clk) begin
    tdo_meta <= link.tdo;
    tdo_sync <= tdo_meta;
    oe_meta <= link.tdo_oe;
    oe_sync <= oe_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // tms sequence: header, shift bits, tail; all end in idle, all but reset start there
  always_comb begin
    scan = (kind == CMD_IR) || (kind == CMD_DR);
    samp_bit = oe_sync ? tdo_sync : 1'b1;
    hdr = (kind == CMD_IR) ? 7'h04 : (kind == CMD_DR) ? 7'h03 :
          (kind == CMD_RESET) ? 7'h05 : 7'h00;
    shn = scan ? {1'b0, len} : 7'h00;
    tail = scan ? 7'h02 : (kind == CMD_RESET) ? 7'h01 : {1'b0, len};
    total = 7'(hdr + shn + tail);
    in_shift = (step >= hdr) && (step < 7'(hdr + shn));
  end

  always_comb begin
    next_busy = busy;
    next_cnt = cnt;
    next_step = step;
    next_kind = kind;
    next_len = len;
    next_data = data;
    next_acc = acc;
    next_tck = tck_r;
    next_tms = tms_r;
    next_tdi = tdi_r;
    next_ready = cmd_ready;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    if (!busy) begin
      if (cmd_valid) begin
        next_busy = 1'b1;
        next_ready = 1'b0;
        next_cnt = 3'h0;
        next_step = 7'h00;
        next_kind = cmd_kind;
        next_len = cmd_len;
        next_data = cmd_data;
        next_acc = 32'h0000_0000;
      end
    end else begin
      next_cnt = (cnt == 3'(TCK_PERIOD_CYC - 1)) ? 3'h0 : 3'(cnt + 3'h1);
      if (cnt == 3'h0) begin
        // R15
        next_tck = 1'b0;
        if (step == total) begin
          // closing fall keeps the last high phase full length and lets the device drive
          next_cnt = 3'h0;
          next_busy = 1'b0;
          next_ready = 1'b1;
          next_rsp_valid = 1'b1;
          next_rsp_data = scan ? (acc >> (7'd32 - {1'b0, len})) : 32'h0000_0000;
        end else begin
          next_tdi = in_shift ? data[5'(step - hdr)] : 1'b0;
          if (step < hdr) begin
            next_tms = (kind == CMD_RESET) ? 1'b1 :
                       (kind == CMD_IR) ? (step < 7'h02) : (step == 7'h00); // R17
          end else if (in_shift) begin
            next_tms = (step == 7'(hdr + shn - 7'h01)); // R16
          end else begin
            next_tms = scan && (step == 7'(hdr + shn));
          end
        end
      end
      if (cnt == 3'(TCK_HALF_CYC)) begin
        next_tck = 1'b1;
      end
      if (cnt == 3'(TCK_PERIOD_CYC - 1)) begin
        if (in_shift) begin
          next_acc = {samp_bit, acc[31:1]}; // R16
        end
        next_step = 7'(step + 7'h01);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      busy <= 1'b0;
      cnt <= 3'h0;
      step <= 7'h00;
      kind <= CMD_RESET;
      len <= 6'h00;
      data <= 32'h0000_0000;
      acc <= 32'h0000_0000;
      tck_r <= 1'b0;
      tms_r <= 1'b1;
      tdi_r <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 32'h0000_0000;
    end else begin
      busy <= next_busy;
      cnt <= next_cnt;
      step <= next_step;
      kind <= next_kind;
      len <= next_len;
      data <= next_data;
      acc <= next_acc;
      tck_r <= next_tck;
      tms_r <= next_tms;
      tdi_r <= next_tdi;
      cmd_ready <= next_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
    end
  end

  assign link.tck = tck_r;
  assign link.tms = tms_r;
  assign link.tdi = tdi_r;
endmodule
`default_nettype wire

// file: test/brte_props.sv
// assertions on the tap link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module brte_props
  import brte_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // tap follower; the tck domain has no reset, so it is trusted only after five tms-high rises
  brte_tap_t st = TAP_TLR;
  brte_tap_t next_st;
  logic [2:0] ones = 3'h0;
  logic [2:0] next_ones;
  logic known = 1'b0;
  logic next_known;
  always_comb begin
    next_ones = tms ? ((ones == 3'h4) ? ones : ones + 3'h1) : 3'h0;
    next_known = known | (tms && ones == 3'h4);
    case (st)
      TAP_TLR: next_st = tms ? TAP_TLR : TAP_RTI;
      TAP_RTI, TAP_UPD_DR, TAP_UPD_IR: next_st = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: next_st = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_SEL_IR: next_st = tms ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_DR, TAP_SHIFT_DR: next_st = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_CAP_IR, TAP_SHIFT_IR: next_st = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_DR: next_st = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_EXIT1_IR: next_st = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_DR: next_st = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_PAUSE_IR: next_st = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_DR: next_st = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      default: next_st = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
    endcase
    if (tms && ones == 3'h4) begin
      next_st = TAP_TLR;
    end
  end
  always_ff @(posedge tck) begin
    st <= next_st;
    ones <= next_ones;
    known <= next_known;
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_tms_fall;
    @(posedge ref_clk) disable iff (!resetn) $changed(tms) |-> !tck;
  endproperty
  a_tms_fall: assert property (p_tms_fall) else $error("tms moved with tck high");
  property p_tdi_fall;
    @(posedge ref_clk) disable iff (!resetn) $changed(tdi) |-> !tck;
  endproperty
  a_tdi_fall: assert property (p_tdi_fall) else $error("tdi moved with tck high");
  property p_tdo_fall;
    @(posedge ref_clk) disable iff (!resetn) $changed(tdo) |-> $fell(tck);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off a falling edge");
  property p_oe_fall;
    @(posedge ref_clk) disable iff (!resetn) $changed(tdo_oe) |-> $fell(tck);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved off a fall");
  property p_tck_high;
    @(posedge ref_clk) disable iff (!resetn) $rose(tck) |=> tck ##1 !tck;
  endproperty
  a_tck_high: assert property (p_tck_high) else $error("tck high phase wrong");
  property p_oe_shift;
    @(posedge tck) disable iff (!known)
      tdo_oe == (st == TAP_SHIFT_DR || st == TAP_SHIFT_IR);
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("tdo enable outside shift");
  property p_oe_exit;
    @(posedge tck) disable iff (!known) (st == TAP_SHIFT_DR) && tms |=> !tdo_oe;
  endproperty
  a_oe_exit: assert property (p_oe_exit) else $error("tdo still on after shift");
  property p_ir_first;
    @(posedge tck) disable iff (!known) (st == TAP_CAP_IR) ##1 (st == TAP_SHIFT_IR) |-> tdo;
  endproperty
  a_ir_first: assert property (p_ir_first) else $error("first ir bit out wrong");
  property p_ir_second;
    @(posedge tck) disable iff (!known)
      (st == TAP_CAP_IR) ##1 (st == TAP_SHIFT_IR) [*2] |-> !tdo;
  endproperty
  a_ir_second: assert property (p_ir_second) else $error("second ir bit out wrong");
  c_shift_dr: cover property (@(posedge tck) st == TAP_SHIFT_DR);
  c_idle_run: cover property (@(posedge tck) (st == TAP_RTI) [*3]);
  c_leave_reset: cover property (@(posedge tck) known && st == TAP_TLR && !tms);
endmodule
`default_nettype wire

// file: test/boundary_run_test_engine_tb.sv
// testbench: host drives the device over the tap link through command requests
`timescale 1ns/1ps
`default_nettype none
module boundary_run_test_engine_tb;
  import brte_pkg::*;
  logic ref_clk;
  logic resetn;
  logic cmd_valid;
  logic [1:0] cmd_kind;
  logic [5:0] cmd_len;
  logic [31:0] cmd_data;
  logic cmd_ready;
  logic rsp_valid;
  logic [31:0] rsp_data;
  logic [7:0] a_side_pins_in, b_side_pins_in;
  logic a_to_b_output_enable, b_to_a_output_enable_n;
  logic [7:0] a_side_pins_out, b_side_pins_out, a_side_core, b_side_core;
  int n_mismatch;
  int check_count;
  brte_link_if link_if ();
  brte_host brte_host_inst (.ref_clk(ref_clk), .resetn(resetn), .link(link_if),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_len(cmd_len), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  brte_device brte_device_inst (.link(link_if), .a_side_pins_in(a_side_pins_in),
    .b_side_pins_in(b_side_pins_in), .a_to_b_output_enable(a_to_b_output_enable),
    .b_to_a_output_enable_n(b_to_a_output_enable_n), .a_side_pins_out(a_side_pins_out),
    .b_side_pins_out(b_side_pins_out), .a_side_core(a_side_core), .b_side_core(b_side_core));
  brte_props brte_props_inst (.ref_clk(ref_clk), .resetn(resetn), .tck(link_if.tck),
    .tms(link_if.tms), .tdi(link_if.tdi), .tdo(link_if.tdo), .tdo_oe(link_if.tdo_oe));
  always #20 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [1:0] k, input logic [5:0] len, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    int nt;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_len <= len;
    cmd_data <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    n = 0;
    nt = (k == CMD_RESET) ? 6 : (k == CMD_IR) ? len + 6 : (k == CMD_DR) ? len + 5 : len;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 2000);
    check(32'(n), 32'(1 + 4 * nt));
    r = rsp_data;
    check({31'h0, cmd_ready}, 32'h0000_0001);
    if (n >= 2000) begin
      wrap_up();
    end
  endtask
  // one engine step of the selected direction; expectations come from here, except the held output shadows in signature-only mode
  function automatic logic [31:0] step(input logic ab, input logic [10:0] ctl,
                                       input logic [7:0] p, input logic [31:0] c);
    logic [7:0] si;
    logic [7:0] so;
    logic [7:0] op;
    logic [7:0] pm;
    logic [15:0] s;
    si = ab ? c[7:0] : c[15:8];
    so = ab ? c[31:24] : c[23:16];
    op = ab ? c[23:16] : c[31:24];
    pm = p & ~ctl[10:3];
    s = {so, si};
    case (ctl[2:0])
      3'h1, 3'h5: {so, si} = {s[14:0], ^(s & TAPS16)};
      3'h2, 3'h6: {so, si} = {s[14:0], ^(s & TAPS16)} ^ {8'h00, pm};
      3'h3: begin
        si = {si[6:0], ^(si & TAPS8)} ^ pm;
        so = {so[6:0], ^(so & TAPS8)};
      end
      3'h7: begin
        si = {si[6:0], ^(si & TAPS8)} ^ pm;
        op = op + {7'h00, so == 8'hFF};
        so = so + 8'h01;
      end
      default: begin
        si = p;
        so = ~so;
      end
    endcase
    return ab ? {so, op, c[15:8], si} : {op, so, si, c[7:0]};
  endfunction
  task automatic run_op(input logic ab, input logic ba_n, input logic [7:0] ir,
                        input logic [10:0] ctl, input logic [31:0] seed, input logic [5:0] n);
    logic [31:0] r;
    logic [31:0] e;
    logic [7:0] held;
    logic live;
    live = (ir == IR_RUN_TEST) && (ab == ba_n);
    @(posedge ref_clk);
    a_to_b_output_enable <= ab;
    b_to_a_output_enable_n <= ba_n;
    cmd(CMD_IR, 6'h08, {24'h0, IR_CTRL_SCAN}, r);
    check(r & 32'hFF, {24'h0, IR_CAPTURE});
    cmd(CMD_DR, 6'h0B, {21'h0, ctl}, r);
    cmd(CMD_IR, 6'h08, {24'h0, IR_CHAIN_READ}, r);
    cmd(CMD_DR, 6'h20, seed, r);
    cmd(CMD_IR, 6'h08, {24'h0, ir}, r);
    held = ab ? b_side_pins_out : a_side_pins_out;
    cmd(CMD_IDLE, n, 32'h0, r);
    e = seed;
    for (int i = 0; i < n; i++) begin
      if (live) begin
        e = step(ab, ctl, ab ? a_side_pins_in : b_side_pins_in, e);
      end
    end
    if (live) begin
      check(ab ? a_side_core : b_side_core, ab ? e[7:0] : e[15:8]);
      check(ab ? b_side_pins_out : a_side_pins_out,
            (ctl[1:0] == 2'h2) ? held : (ab ? e[31:24] : e[23:16]));
      // the idle rise that opens the next scan still runs the engine
      e = step(ab, ctl, ab ? a_side_pins_in : b_side_pins_in, e);
    end
    cmd(CMD_IR, 6'h08, {24'h0, IR_CHAIN_READ}, r);
    cmd(CMD_DR, 6'h20, seed, r);
    check(r, e);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    ref_clk = 1'b0;
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = 2'h0;
    cmd_len = 6'h00;
    cmd_data = 32'h0;
    // pins eight and one are high on both sides so masking shows
    a_side_pins_in = 8'hA5;
    b_side_pins_in = 8'hC3;
    a_to_b_output_enable = 1'b1;
    b_to_a_output_enable_n = 1'b1;
    n_mismatch = 0;
    check_count = 0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    cmd(CMD_RESET, 6'h06, 32'h0, r);
    // bypass after reset: one zero stage ahead of the shifted bits
    cmd(CMD_DR, 6'h04, 32'h0000_0005, r);
    check(r, 32'h0000_000A);
    run_op(1'b1, 1'b1, IR_RUN_TEST, 11'h000, 32'h1234_5678, 6'h03);
    run_op(1'b0, 1'b0, IR_RUN_TEST, 11'h004, 32'h9ABC_DEF0, 6'h02);
    run_op(1'b1, 1'b1, IR_RUN_TEST, 11'h001, 32'h8100_0042, 6'h05);
    run_op(1'b0, 1'b0, IR_RUN_TEST, 11'h005, 32'h0000_0000, 6'h04);
    run_op(1'b0, 1'b0, IR_RUN_TEST, 11'h005, 32'h00C3_1800, 6'h06);
    run_op(1'b1, 1'b1, IR_RUN_TEST, 11'h002, 32'h0000_0011, 6'h04);
    run_op(1'b1, 1'b1, IR_RUN_TEST, {8'h81, 3'h6}, 32'h0000_0011, 6'h04);
    run_op(1'b0, 1'b0, IR_RUN_TEST, {8'h0F, 3'h3}, 32'h5500_3300, 6'h05);
    run_op(1'b1, 1'b1, IR_RUN_TEST, {8'h00, 3'h7}, 32'hFD00_0007, 6'h03);
    run_op(1'b0, 1'b0, IR_RUN_TEST, {8'h30, 3'h7}, 32'h01FE_0000, 6'h02);
    run_op(1'b1, 1'b0, IR_RUN_TEST, 11'h000, 32'h0F0F_0F0F, 6'h03);
    run_op(1'b0, 1'b1, IR_RUN_TEST, 11'h001, 32'h0F0F_0F0F, 6'h03);
    run_op(1'b1, 1'b1, IR_BYPASS, 11'h000, 32'h3C3C_3C3C, 6'h03);
    wrap_up();
  end
endmodule
`default_nettype wire
